// >>> hdl/imec_top.sv
// Interrupt mask threshold, external edge latch clear and raw pending view.
// Assumes synchronous inputs, a single clock and an Avalon-MM master that
// holds each request until waitrequest is sampled low.
//
// The implementer's own choice: the Avalon-MM register port.
`timescale 1ns/1ns
`default_nettype none

module imec_top
  import imec_pkg::*;
(
  // Clock and reset
  input  wire logic                       clk,
  input  wire logic                       rst_n,
  // Avalon-MM slave
  input  wire logic [ADDR_W-1:0]          avs_address,
  input  wire logic                       avs_read,
  input  wire logic                       avs_write,
  input  wire logic [DATA_W-1:0]          avs_writedata,
  input  wire logic [3:0]                 avs_byteenable,
  output logic [DATA_W-1:0]               avs_readdata,
  output logic                            avs_waitrequest,
  // Interrupt sources
  input  wire logic [NUM_SRC-1:0]         src_request,
  input  wire logic [NUM_SRC*LEVEL_W-1:0] source_priority_level,
  input  wire logic [NUM_EXT-1:0]         ext_int_in,
  // Core side
  output logic                            core_irq_req,
  output logic [NUM_EXT-1:0]              edge_latched,
  // Block interrupt
  output logic                            irq
);

  // ----------------------------------------
  // State
  // ----------------------------------------
  typedef struct packed {
    logic [LEVEL_W-1:0] mask_threshold;
    logic [SEL_W-1:0]   edge_clear_source_select;
    logic [NUM_EXT-1:0] ext_prev;
    logic [NUM_EXT-1:0] edge_lat;
    logic [NUM_EXT-1:0] irq_stat;
    logic [NUM_EXT-1:0] irq_mask;
    logic               ack;
    logic [DATA_W-1:0]  rdata;
    logic               core_req;
    logic               irq;
  } imec_state_s;

  imec_state_s st_reg;
  imec_state_s st_next;

  // ----------------------------------------
  // Helpers
  // ----------------------------------------
  function automatic logic imec_level_passes(input logic [LEVEL_W-1:0] lvl,
                                             input logic [LEVEL_W-1:0] thr);
    imec_level_passes = (lvl != LEVEL_OFF) && (lvl > thr);
  endfunction

  function automatic logic imec_hit(input logic [ADDR_W-1:0] a,
                                    input logic [ADDR_W-1:0] ofs);
    imec_hit = (a[ADDR_W-1:2] == ofs[ADDR_W-1:2]);
  endfunction

  // ----------------------------------------
  // Combinational views
  // ----------------------------------------
  logic [NUM_SRC-1:0] pend_view;
  logic [NUM_SRC-1:0] pass_vec;
  logic [NUM_EXT-1:0] edge_rise;
  logic [NUM_EXT-1:0] clr_vec;
  logic               bus_req;
  logic               wr_take;

  always_comb begin
    pend_view = ({src_request[NUM_SRC-1:NUM_EXT],
                  src_request[NUM_EXT-1:0] | st_reg.edge_lat}) & PEND_VALID;
    for (int i = 0; i < NUM_SRC; i++) begin
      pass_vec[i] = pend_view[i]
        && imec_level_passes(source_priority_level[i*LEVEL_W +: LEVEL_W],
                             st_reg.mask_threshold);
    end
  end

  assign edge_rise = ext_int_in & ~st_reg.ext_prev;
  assign bus_req   = avs_read | avs_write;
  assign wr_take   = avs_write & st_reg.ack;

  always_comb begin
    clr_vec = '0;
    if (wr_take && imec_hit(avs_address, OFS_EDGE_CLR) && avs_byteenable[1]
        && avs_writedata[EDGE_CE_BIT]
        && avs_writedata[EDGE_SEL_LSB +: SEL_W] <= EDGE_SEL_MAX) begin
      clr_vec[avs_writedata[EDGE_SEL_LSB +: SEL_W]] = 1'b1;
    end
  end

  // ----------------------------------------
  // Next state
  // ----------------------------------------
  always_comb begin
    st_next          = st_reg;
    st_next.ext_prev = ext_int_in;
    // held until cleared; new edge wins
    st_next.edge_lat = (st_reg.edge_lat & ~clr_vec) | edge_rise;
    st_next.ack      = bus_req & ~st_reg.ack;
    st_next.rdata    = '0;

    if (wr_take) begin
      if (imec_hit(avs_address, OFS_MASK_THR) && avs_byteenable[0]) begin
        st_next.mask_threshold = avs_writedata[MASK_THR_LSB +: LEVEL_W];
      end
      if (imec_hit(avs_address, OFS_EDGE_CLR) && avs_byteenable[0]) begin
        st_next.edge_clear_source_select = avs_writedata[EDGE_SEL_LSB +: SEL_W];
      end
      if (imec_hit(avs_address, OFS_IRQ_MASK)) begin
        if (avs_byteenable[0]) begin
          st_next.irq_mask[7:0] = avs_writedata[7:0];
        end
        if (avs_byteenable[1]) begin
          st_next.irq_mask[9:8] = avs_writedata[9:8];
        end
      end
    end

    // Status: write one clears, new edge wins
    st_next.irq_stat = st_reg.irq_stat;
    if (wr_take && imec_hit(avs_address, OFS_IRQ_STAT)) begin
      if (avs_byteenable[0]) begin
        st_next.irq_stat[7:0] = st_reg.irq_stat[7:0] & ~avs_writedata[7:0];
      end
      if (avs_byteenable[1]) begin
        st_next.irq_stat[9:8] = st_reg.irq_stat[9:8] & ~avs_writedata[9:8];
      end
    end
    st_next.irq_stat = st_next.irq_stat | edge_rise;

    // Read data loads on the acknowledge edge
    if (avs_read && !st_reg.ack) begin
      if (imec_hit(avs_address, OFS_MASK_THR)) begin
        st_next.rdata[MASK_THR_LSB +: LEVEL_W] = st_reg.mask_threshold;
      end else if (imec_hit(avs_address, OFS_EDGE_CLR)) begin
        st_next.rdata[EDGE_SEL_LSB +: SEL_W] = st_reg.edge_clear_source_select;
      end else if (imec_hit(avs_address, OFS_PENDING)) begin
        st_next.rdata = pend_view;
      end else if (imec_hit(avs_address, OFS_IRQ_STAT)) begin
        st_next.rdata[NUM_EXT-1:0] = st_reg.irq_stat;
      end else if (imec_hit(avs_address, OFS_IRQ_MASK)) begin
        st_next.rdata[NUM_EXT-1:0] = st_reg.irq_mask;
      end
    end

    st_next.core_req = |pass_vec;
    st_next.irq      = |(st_next.irq_stat & st_next.irq_mask);

    if (!rst_n) begin
      st_next                          = '0;
      st_next.mask_threshold           = MASK_THR_RST;
      st_next.edge_clear_source_select = EDGE_SEL_RST;
      st_next.irq_mask                 = IRQ_MASK_RST;
    end
  end

  always_ff @(posedge clk) begin
    st_reg <= st_next;
  end

  // ----------------------------------------
  // Outputs
  // ----------------------------------------
  assign avs_waitrequest = bus_req & ~st_reg.ack;
  assign avs_readdata    = st_reg.rdata;
  assign core_irq_req    = st_reg.core_req;
  assign edge_latched    = st_reg.edge_lat;
  assign irq             = st_reg.irq;

endmodule

`default_nettype wire

// >>> common/imec_pkg.sv
// Constants for the interrupt mask, edge clear and pending block.
// Assumes a 32-bit Avalon-MM slave with byte addresses and one 100 MHz clock.
package imec_pkg;

  // ----------------------------------------
  // Widths
  // ----------------------------------------
  localparam int unsigned ADDR_W    = 16;
  localparam int unsigned DATA_W    = 32;
  localparam int unsigned LEVEL_W   = 3;
  localparam int unsigned NUM_SRC   = 32;
  localparam int unsigned SEL_W     = 4;
  localparam int unsigned NUM_EXT   = 10;

  // ----------------------------------------
  // Register offsets (byte addresses)
  // ----------------------------------------
  localparam logic [15:0] OFS_MASK_THR  = 16'hf640;
  localparam logic [15:0] OFS_EDGE_CLR  = 16'hf660;
  localparam logic [15:0] OFS_PENDING   = 16'hf680;
  localparam logic [15:0] OFS_IRQ_STAT  = 16'hf6a0;
  localparam logic [15:0] OFS_IRQ_MASK  = 16'hf6a4;

  // ----------------------------------------
  // Field positions
  // ----------------------------------------
  localparam int unsigned MASK_THR_LSB  = 0;
  localparam int unsigned EDGE_SEL_LSB  = 0;
  localparam int unsigned EDGE_CE_BIT   = 8;
  localparam int unsigned PEND_RSVD_BIT = 20;

  // ----------------------------------------
  // Values after reset and codes
  // ----------------------------------------
  localparam logic [2:0]  MASK_THR_RST  = 3'h0;
  localparam logic [3:0]  EDGE_SEL_RST  = 4'h0;
  localparam logic [9:0]  IRQ_MASK_RST  = 10'h000;
  localparam logic [2:0]  LEVEL_OFF     = 3'h0;
  localparam logic [3:0]  EDGE_SEL_MAX  = 4'h9;
  localparam logic [31:0] PEND_VALID    = 32'hffef_ffff;

endpackage

// >>> tb/imec_core_model.sv
// Core side stand-in: counts requests raised toward the processor.
// Assumes core_irq_req is a registered level from the block.
`timescale 1ns/1ns
`default_nettype none
module imec_core_model (
  // Clock and reset
  input  wire logic       clk,
  input  wire logic       rst_n,
  // Request from the block
  input  wire logic       core_irq_req,
  output logic [7:0]      n_rise
);
  logic seen_q;
  always_ff @(posedge clk) begin
    seen_q <= rst_n && core_irq_req;
    if (!rst_n) n_rise <= '0;
    else if (core_irq_req && !seen_q) n_rise <= n_rise + 8'h01;
  end
endmodule
`default_nettype wire

// >>> tb/imec_monitor.sv
// Checker on imec_top ports: threshold, edge latch, pending view.
// Bound to every imec_top; one clock, synchronous reset.
`timescale 1ns/1ns
`default_nettype none
module imec_monitor
  import imec_pkg::*;
(
  // Clock, reset, bus
  input wire logic        clk,
  input wire logic        rst_n,
  input wire logic [15:0] avs_address,
  input wire logic        avs_read,
  input wire logic        avs_write,
  input wire logic [31:0] avs_writedata,
  input wire logic [3:0]  avs_byteenable,
  input wire logic [31:0] avs_readdata,
  input wire logic        avs_waitrequest,
  // Sources and outputs
  input wire logic [31:0] src_request,
  input wire logic [95:0] source_priority_level,
  input wire logic [9:0]  ext_int_in,
  input wire logic        core_irq_req,
  input wire logic [9:0]  edge_latched
);
  logic [9:0]  ext_q, rise;
  logic [31:0] src_q;
  logic [3:0]  sel_q;
  logic [2:0]  thr_q, lv;
  logic        acc, rda, clr, clr_ok, pass, blk;
  assign acc = avs_write && !avs_waitrequest;
  assign rda = avs_read && !avs_waitrequest;
  assign lv = source_priority_level[95:93];
  assign rise = ext_int_in & ~ext_q;
  assign clr = acc && avs_address == OFS_EDGE_CLR && avs_byteenable[1] && avs_writedata[8];
  assign clr_ok = clr && avs_writedata[3:0] <= 4'h9 && !rise[avs_writedata[3:0]];
  assign pass = src_request[31] && lv > thr_q;
  assign blk = src_request == 32'h8000_0000 && edge_latched == '0 && lv <= thr_q;
  always_ff @(posedge clk) begin
    ext_q <= rst_n ? ext_int_in : '0;
    src_q <= src_request;
    sel_q <= avs_writedata[3:0];
    if (!rst_n) thr_q <= '0;
    else if (acc && avs_address == OFS_MASK_THR) thr_q <= avs_writedata[2:0];
  end
  default clocking cb @(posedge clk); endclocking
  default disable iff (!rst_n);
  a_edge_set: assert property (rise != '0 |=> (edge_latched & $past(rise)) == $past(rise))
    else $error("edge latch missed");
  a_latch_hold: assert property ($past(rst_n) && ($past(edge_latched) & ~edge_latched) != '0
    |-> $past(clr)) else $error("edge latch lost");
  a_clr_sel: assert property (clr_ok |=> !edge_latched[sel_q]) else $error("clear missed");
  a_thr_all_off: assert property ($past(thr_q) == 3'h7 |-> !core_irq_req)
    else $error("threshold seven passed");
  a_thr_pass: assert property ($past(rst_n) && $past(pass) |-> core_irq_req)
    else $error("level above threshold blocked");
  a_thr_eq_blk: assert property ($past(rst_n) && $past(blk) |-> !core_irq_req)
    else $error("level at threshold passed");
  a_ce_reads_zero: assert property (rda && avs_address == OFS_EDGE_CLR |-> !avs_readdata[8])
    else $error("clear enable read one");
  a_pend_raw: assert property (rda && avs_address == OFS_PENDING
    |-> avs_readdata[31:10] == {src_q[31:21], 1'b0, src_q[19:10]}) else $error("pending wrong");
  c_clear: cover property (clr_ok);
  c_pass: cover property (pass && core_irq_req);
  c_pend: cover property (rda && avs_address == OFS_PENDING);
endmodule
bind imec_top imec_monitor u_mon(.clk(clk), .rst_n(rst_n), .avs_address(avs_address),
  .avs_read(avs_read), .avs_write(avs_write), .avs_writedata(avs_writedata),
  .avs_byteenable(avs_byteenable), .avs_readdata(avs_readdata),
  .avs_waitrequest(avs_waitrequest), .src_request(src_request), .ext_int_in(ext_int_in),
  .source_priority_level(source_priority_level), .core_irq_req(core_irq_req),
  .edge_latched(edge_latched));
`default_nettype wire

// >>> tb/test_imec_top.sv
// Bench for imec_top: registers, threshold, edge latches, pending view.
// Assumes the core model and the checker are compiled first.
`timescale 1ns/1ns
`default_nettype none
module test_imec_top;
  import imec_pkg::*;
  logic        clk, rst_n, rd, wr, cirq, irq, wq;
  logic [15:0] a;
  logic [31:0] wd, rdat, src, lf;
  logic [95:0] lvl;
  logic [9:0]  ext, elat;
  logic [3:0]  be;
  logic [7:0]  n_rise;
  logic [31:0] q[$];
  int          n_fail, tests_run;
  imec_top u_dut(.clk(clk), .rst_n(rst_n), .avs_address(a), .avs_read(rd), .avs_write(wr),
    .avs_writedata(wd), .avs_byteenable(be), .avs_readdata(rdat), .avs_waitrequest(wq),
    .src_request(src), .source_priority_level(lvl), .ext_int_in(ext),
    .core_irq_req(cirq), .edge_latched(elat), .irq(irq));
  imec_core_model u_core(.clk(clk), .rst_n(rst_n), .core_irq_req(cirq), .n_rise(n_rise));
  initial begin
    clk = 0;
    forever #5 clk = ~clk;
  end
  task automatic test_done;
    $display("checks %0d mismatches %0d", tests_run, n_fail);
    if (n_fail == 0 && tests_run > 0) $display("Test passed");
    else $display("Test failed");
    $finish;
  endtask
  task automatic chk(string s, logic [31:0] e, logic [31:0] g);
    tests_run++;
    if (g !== e) begin
      n_fail++;
      $display("[ERR] %s exp %h got %h", s, e, g);
    end
  endtask
  task automatic bus(logic w, logic [15:0] ad, logic [31:0] d);
    int n;
    @(posedge clk);
    {wr, rd, a, wd} <= {w, !w, ad, d};
    n = 0;
    do begin
      @(posedge clk);
      n++;
    end while (wq !== 1'b0 && n < 20);
    if (wq !== 1'b0) begin
      n_fail++;
      test_done;
    end
    {wr, rd} <= 2'b00;
  endtask
  task automatic rdx(logic [15:0] ad, logic [31:0] e);
    q.push_back(e);
    bus(1'b0, ad, '0);
  endtask
  function automatic logic [31:0] nx(logic [31:0] v);
    return {v[30:0], v[31] ^ v[21] ^ v[1] ^ v[0]};
  endfunction
  // Read results leave the queue here
  always @(posedge clk)
    if (rd && wq === 1'b0) chk("readdata", q.pop_front(), rdat);
  initial begin
    {rst_n, rd, wr, a, wd, src, lvl, ext} = '0;
    be = 4'hf;
    lf = 32'h0000_b6b4;
    repeat (16) @(posedge clk);
    rst_n <= 1'b1;
    rdx(OFS_MASK_THR, '0);
    rdx(OFS_EDGE_CLR, '0);
    rdx(OFS_PENDING, '0);
    rdx(16'hf700, '0);
    src <= 32'h8000_0000;
    for (int t = 0; t < 8; t++) begin
      bus(1'b1, OFS_MASK_THR, 32'(t));
      rdx(OFS_MASK_THR, 32'(t));
      for (int l = 0; l < 8; l++) begin
        lvl[95:93] <= 3'(l);
        repeat (3) @(posedge clk);
        chk("core_irq_req", 32'(l != 0 && l > t), 32'(cirq));
      end
    end
    chk("core rises", 32'h0000_0007, 32'(n_rise));
    {src, lvl} <= '0;
    bus(1'b1, OFS_IRQ_MASK, 32'h0000_03ff);
    for (int k = 0; k < 10; k++) begin
      ext[k] <= 1'b1;
      repeat (2) @(posedge clk);
      ext[k] <= 1'b0;
      chk("edge_latched", 32'(1 << k), 32'(elat));
      chk("irq", 32'h0000_0001, 32'(irq));
      bus(1'b1, OFS_EDGE_CLR, 32'h0000_0100 | 32'((k + 1) % 10));
      bus(1'b1, OFS_EDGE_CLR, 32'(k));
      be <= 4'h1;
      bus(1'b1, OFS_EDGE_CLR, 32'(k) | 32'h0000_0100);
      be <= 4'hf;
      rdx(OFS_PENDING, 32'(1 << k));
      bus(1'b1, OFS_EDGE_CLR, 32'(k) | 32'h0000_0100);
      rdx(OFS_EDGE_CLR, 32'(k));
      chk("edge_latched", '0, 32'(elat));
      rdx(OFS_IRQ_STAT, 32'(1 << k));
      bus(1'b1, OFS_IRQ_STAT, 32'(1 << k));
      repeat (2) @(posedge clk);
      chk("irq", '0, 32'(irq));
    end
    bus(1'b1, OFS_IRQ_MASK, '0);
    ext[0] <= 1'b1;
    repeat (2) @(posedge clk);
    chk("irq", '0, 32'(irq));
    bus(1'b1, OFS_IRQ_MASK, 32'h0000_0001);
    repeat (2) @(posedge clk);
    chk("irq", 32'h0000_0001, 32'(irq));
    repeat (8) begin
      lf = nx(lf);
      src <= lf;
      rdx(OFS_PENDING, (lf & PEND_VALID) | 32'h0000_0001);
    end
    test_done;
  end
endmodule
`default_nettype wire
